//--- core/led_consts.vh
// Constants for the status indicator encoder of a six-channel output module.
// Assumes a 50 MHz system clock and one LED driver pin per colour.
// Summary of operation
// RQ1: Run LED dark unpowered, single flash reset, double update, flash preop, steady run.
// RQ2: Error LED dark no error, flash boot loader, triple update, steady on error.
// RQ3: Channel LED red on channel error or non-safety use, orange while set.
// RQ4: During start-up every channel LED is steady red.
// RQ5: Safety-state lamp dark in run state or without field supply.
// RQ6: Safety-state lamp red pattern in boot, link loss, cpu fail, preop, comm fault.
// RQ7: Safety-state lamp dedicated red pattern for uncertified pilot firmware.
// RQ8: Safety-state lamp steady when safety-related status is active.
// RQ9: Steady safety-state lamp also raises inoperative diagnostic to the controller.
// RQ10: Invalid configuration gives steady error LED and single green flashes.
// RQ11: Flash bursts repeat periodically with a visible dark gap.
`ifndef LED_CONSTS_VH
`define LED_CONSTS_VH

// Last count of one 200 ms flash slot at 50 MHz
`define SLOT_LAST 24'h98_967f
// Slots in one pattern period: bursts use the first six, blink lights every even slot up to 8
`define SLOTS_PER_PERIOD 4'ha
`define NUM_CH 6

// Module state codes
`define ST_NO_SUPPLY 4'h0
`define ST_RESET 4'h1
`define ST_FW_UPDATE 4'h2
`define ST_BOOT_LOADER 4'h3
`define ST_PREOP 4'h4
`define ST_RUN 4'h5
`define ST_ERROR 4'h6
`define ST_BAD_CONFIG 4'h7
`define ST_STARTUP 4'h8
`define ST_SAFE_ACTIVE 4'h9

// Slot patterns, bit n lit in slot n
`define PAT_SINGLE 10'h001
`define PAT_DOUBLE 10'h005
`define PAT_TRIPLE 10'h015
`define PAT_BLINK 10'h155
`define PAT_PILOT 10'h03f

`endif

//--- core/flash_timer.v
// Slot timer that steps through the flash pattern period.
// Assumes a synchronous active-high reset from the top.
`timescale 1ns/1ps
`include "led_consts.vh"
module flash_timer (
    input wire clk,
    input wire rst,
    output reg [3:0] slot_q
);
    reg [23:0] cnt_q;

    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= 24'h00_0000;
            slot_q <= 4'h0;
        end else if (cnt_q == `SLOT_LAST) begin
            cnt_q <= 24'h00_0000;
            if (slot_q == `SLOTS_PER_PERIOD - 4'h1) begin
                slot_q <= 4'h0; // RQ11
            end else begin
                slot_q <= slot_q + 4'h1;
            end
        end else begin
            cnt_q <= cnt_q + 24'h00_0001;
        end
    end
endmodule // flash_timer

//--- core/status_leds.v
// Status indicator encoder: module state and channel flags to LED drives.
// Assumes inputs arrive from outside the clock domain and are synchronised.
`timescale 1ns/1ps
`include "led_consts.vh"
module status_leds (
    input wire clk,
    input wire arst_n,
    input wire [3:0] mod_state,
    input wire field_supply_ok,
    input wire link_lost,
    input wire cpu_failed,
    input wire comm_fault,
    input wire fw_inoperable,
    input wire fw_pilot,
    input wire [5:0] ch_error,
    input wire [5:0] ch_nonsafe,
    input wire [5:0] ch_set,
    output reg run_led_q,
    output reg err_led_q,
    output reg [5:0] ch_red_q,
    output reg [5:0] ch_orange_q,
    output reg safety_state_lamp_q,
    output reg inoperative_diag_q
);
    // Internal reset: asserts at once, releases two edges late
    reg rst_s1_q;
    reg rst_s2_q;
    wire rst = ~rst_s2_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // Two-stage synchronisers for all status inputs
    localparam W = 4 + 6 + 18;
    wire [W-1:0] raw = {mod_state, field_supply_ok, link_lost, cpu_failed,
        comm_fault, fw_inoperable, fw_pilot, ch_error, ch_nonsafe, ch_set};
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    always @(posedge clk) begin
        if (rst) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    // The state code is a word: take it only when two samples agree,
    // so a code caught mid-change never reaches the indicators
    reg [3:0] st_s3_q;
    reg [3:0] st_q;
    always @(posedge clk) begin
        if (rst) begin
            st_s3_q <= `ST_NO_SUPPLY;
            st_q <= `ST_NO_SUPPLY;
        end else begin
            st_s3_q <= s2_q[27:24];
            if (s2_q[27:24] == st_s3_q) begin
                st_q <= st_s3_q;
            end
        end
    end

    wire [3:0] st = st_q;
    wire fsup = s2_q[23];
    wire lnk = s2_q[22];
    wire cpu = s2_q[21];
    wire com = s2_q[20];
    wire fwin = s2_q[19];
    wire pil = s2_q[18];
    wire [5:0] cerr = s2_q[17:12];
    wire [5:0] cns = s2_q[11:6];
    wire [5:0] cset = s2_q[5:0];

    wire [3:0] slot;
    flash_timer u_timer (
        .clk(clk),
        .rst(rst),
        .slot_q(slot)
    );

    // Lit or dark for the given slot of a pattern
    function pat_on;
        input [9:0] pat;
        input [3:0] s;
        begin
            pat_on = pat[s];
        end
    endfunction

    // Start-up and boot loader both count as boot phase for the lamp
    function boot_phase;
        input [3:0] s;
        begin
            boot_phase = (s == `ST_STARTUP) || (s == `ST_BOOT_LOADER);
        end
    endfunction

    // Next values for the output flip-flops
    reg run_d;
    reg err_d;
    reg [5:0] red_d;
    reg [5:0] org_d;
    reg lamp_d;
    reg diag_d;

    // Green run indicator; unknown codes leave it dark
    always @* begin
        run_d = 1'b0;
        case (st)
            `ST_RESET: begin
                run_d = pat_on(`PAT_SINGLE, slot); // RQ1
            end
            `ST_FW_UPDATE: begin
                run_d = pat_on(`PAT_DOUBLE, slot); // RQ1
            end
            `ST_PREOP: begin
                run_d = pat_on(`PAT_BLINK, slot); // RQ1
            end
            `ST_RUN: begin
                run_d = 1'b1; // RQ1
            end
            `ST_BAD_CONFIG: begin
                run_d = pat_on(`PAT_SINGLE, slot); // RQ10
            end
            default: begin
                run_d = 1'b0; // RQ1
            end
        endcase
    end

    // Red error indicator
    always @* begin
        err_d = 1'b0;
        case (st)
            `ST_FW_UPDATE: begin
                err_d = pat_on(`PAT_TRIPLE, slot); // RQ2
            end
            `ST_BOOT_LOADER: begin
                err_d = pat_on(`PAT_BLINK, slot); // RQ2
            end
            `ST_ERROR: begin
                err_d = 1'b1; // RQ2
            end
            `ST_BAD_CONFIG: begin
                err_d = 1'b1; // RQ10
            end
            default: begin
                err_d = 1'b0; // RQ2
            end
        endcase
    end

    // Channel indicators; red wins over orange on a channel
    always @* begin
        if (st == `ST_STARTUP) begin
            red_d = 6'h3f; // RQ4
            org_d = 6'h00; // RQ4
        end else begin
            red_d = cerr | cns; // RQ3
            org_d = cset & ~red_d; // RQ3
        end
    end

    // Safety-state lamp: dark beats steady beats pilot beats alarms
    always @* begin
        lamp_d = 1'b0;
        diag_d = 1'b0;
        if (st == `ST_NO_SUPPLY || st == `ST_RUN || !fsup) begin
            lamp_d = 1'b0; // RQ5
        end else if (st == `ST_SAFE_ACTIVE) begin
            lamp_d = 1'b1; // RQ8
            diag_d = 1'b1; // RQ9
        end else if (pil) begin
            lamp_d = pat_on(`PAT_PILOT, slot); // RQ7
        end else if (lnk || cpu || com || fwin) begin
            lamp_d = pat_on(`PAT_BLINK, slot); // RQ6
        end else if (st == `ST_PREOP || boot_phase(st)) begin
            // Pre-operational and boot phases blink like faults
            lamp_d = pat_on(`PAT_BLINK, slot); // RQ6
        end else begin
            lamp_d = 1'b0;
        end
    end

    // Every output pin comes straight from a flip-flop
    // Run and error indicators
    always @(posedge clk) begin
        if (rst) begin
            run_led_q <= 1'b0;
            err_led_q <= 1'b0;
        end else begin
            run_led_q <= run_d;
            err_led_q <= err_d;
        end
    end

    // Channel indicators
    always @(posedge clk) begin
        if (rst) begin
            ch_red_q <= 6'h00;
            ch_orange_q <= 6'h00;
        end else begin
            ch_red_q <= red_d;
            ch_orange_q <= org_d;
        end
    end

    // Safety-state lamp and its diagnostic
    always @(posedge clk) begin
        if (rst) begin
            safety_state_lamp_q <= 1'b0;
            inoperative_diag_q <= 1'b0;
        end else begin
            safety_state_lamp_q <= lamp_d;
            inoperative_diag_q <= diag_d;
        end
    end
endmodule // status_leds

//--- dv/status_leds_properties.sv
// Checker for the steady indicator outputs of the status encoder
// Bound to status_leds; led_consts.vh on the include path
`timescale 1ns/1ps
`include "led_consts.vh"
module status_leds_properties (
    input wire clk,
    input wire arst_n,
    input wire [3:0] mod_state,
    input wire field_supply_ok,
    input wire [5:0] ch_error,
    input wire [5:0] ch_nonsafe,
    input wire [5:0] ch_set,
    input wire run_led_q,
    input wire err_led_q,
    input wire [5:0] ch_red_q,
    input wire [5:0] ch_orange_q,
    input wire safety_state_lamp_q,
    input wire inoperative_diag_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire run = mod_state == `ST_RUN;
    wire [5:0] bad = ch_error | ch_nonsafe;
    AST_RUN: assert property (
        run [*7] |-> run_led_q && !safety_state_lamp_q)
        else $error("run state indicators wrong");
    AST_DARK: assert property (
        (mod_state == `ST_NO_SUPPLY) [*7] |-> !run_led_q && !err_led_q)
        else $error("unpowered indicators lit");
    AST_ERR: assert property (
        (mod_state == `ST_ERROR) [*7] |-> err_led_q)
        else $error("error lamp not steady");
    AST_BADCFG: assert property (
        (mod_state == `ST_BAD_CONFIG) [*7] |-> err_led_q)
        else $error("bad config error lamp dark");
    AST_START: assert property (
        (mod_state == `ST_STARTUP) [*7] |-> &ch_red_q)
        else $error("start-up channels not red");
    AST_RED: assert property (
        (run && $stable(bad)) [*7] |-> ch_red_q == bad)
        else $error("channel red mismatch");
    AST_ORANGE: assert property (
        (run && $stable(bad) && $stable(ch_set)) [*7]
        |-> ch_orange_q == (ch_set & ~bad))
        else $error("channel orange mismatch");
    AST_FIELD: assert property (
        (!field_supply_ok) [*7] |-> !safety_state_lamp_q)
        else $error("lamp lit without field supply");
    AST_SAFE: assert property (
        (mod_state == `ST_SAFE_ACTIVE && field_supply_ok) [*7]
        |-> safety_state_lamp_q && inoperative_diag_q)
        else $error("safe state not shown");
    AST_DIAG: assert property (
        inoperative_diag_q |-> safety_state_lamp_q)
        else $error("diagnostic without steady lamp");
endmodule // status_leds_properties

//--- dv/status_leds_test.sv
// Self-checking bench for the status indicator encoder
// Whole run sits in the first flash slot, where every pattern is lit
`timescale 1ns/1ps
`include "led_consts.vh"
module status_leds_test;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg [3:0] st = `ST_NO_SUPPLY;
    reg fok = 1'b1;
    reg [4:0] flt = 5'h00;
    reg [5:0] err = 6'h00;
    reg [5:0] ns = 6'h00;
    reg [5:0] set = 6'h00;
    wire run_q, err_q, lamp_q, diag_q;
    wire [5:0] red_q, org_q;
    integer miscompares = 0;
    integer total_checks = 0;
    always #10 clk = ~clk;
    status_leds u_status_leds (.clk(clk), .arst_n(arst_n),
        .mod_state(st), .field_supply_ok(fok), .link_lost(flt[4]),
        .cpu_failed(flt[3]), .comm_fault(flt[2]),
        .fw_inoperable(flt[1]), .fw_pilot(flt[0]), .ch_error(err),
        .ch_nonsafe(ns), .ch_set(set), .run_led_q(run_q),
        .err_led_q(err_q), .ch_red_q(red_q), .ch_orange_q(org_q),
        .safety_state_lamp_q(lamp_q), .inoperative_diag_q(diag_q));
    task chk(input [7:0] got, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("unexpected %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task go(input [3:0] s);
        begin
            @(posedge clk);
            #1 st = s;
            repeat (7) @(posedge clk);
            #1;
        end
    endtask
    task t_dark;
        begin
            go(`ST_NO_SUPPLY);
            chk(run_q, 1'b0);
            chk(err_q, 1'b0);
        end
    endtask
    task t_run;
        begin
            set = 6'h2a;
            go(`ST_RUN);
            chk(run_q, 1'b1);
            chk(lamp_q, 1'b0);
            chk(org_q, 6'h2a);
            chk(red_q, 6'h00);
        end
    endtask
    task t_chan;
        begin
            err = 6'h01;
            ns = 6'h20;
            set = 6'h23;
            go(`ST_RUN);
            chk(red_q, 6'h21);
            chk(org_q, 6'h02);
            go(`ST_STARTUP);
            chk(red_q, 6'h3f);
            chk(org_q, 6'h00);
        end
    endtask
    task t_err;
        begin
            go(`ST_ERROR);
            chk(err_q, 1'b1);
            go(`ST_BAD_CONFIG);
            chk(err_q, 1'b1);
        end
    endtask
    task t_flash;
        begin
            go(`ST_RESET);
            chk(run_q, 1'b1);
            go(`ST_FW_UPDATE);
            chk(run_q, 1'b1);
            chk(err_q, 1'b1);
            go(`ST_BOOT_LOADER);
            chk(err_q, 1'b1);
            chk(lamp_q, 1'b1);
            go(`ST_PREOP);
            chk(run_q, 1'b1);
            chk(lamp_q, 1'b1);
            go(`ST_BAD_CONFIG);
            chk(run_q, 1'b1);
            flt = 5'h10;
            go(`ST_ERROR);
            chk(lamp_q, 1'b1);
            flt = 5'h01;
            go(`ST_ERROR);
            chk(lamp_q, 1'b1);
            go(`ST_RUN);
            chk(lamp_q, 1'b0);
            flt = 5'h00;
        end
    endtask
    task t_safe;
        begin
            go(`ST_SAFE_ACTIVE);
            chk(lamp_q, 1'b1);
            chk(diag_q, 1'b1);
            fok = 1'b0;
            go(`ST_SAFE_ACTIVE);
            chk(lamp_q, 1'b0);
            chk(diag_q, 1'b0);
            fok = 1'b1;
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d miscompares %0d", total_checks, miscompares);
            if (miscompares == 0 && total_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 arst_n = 1'b1;
        t_dark;
        t_run;
        t_chan;
        t_err;
        t_flash;
        t_safe;
        print_verdict;
    end
    initial begin
        #20000;
        miscompares = miscompares + 1;
        print_verdict;
    end
endmodule // status_leds_test
bind status_leds status_leds_properties u_chk (
    .clk(clk),
    .arst_n(arst_n),
    .mod_state(mod_state),
    .field_supply_ok(field_supply_ok),
    .ch_error(ch_error),
    .ch_nonsafe(ch_nonsafe),
    .ch_set(ch_set),
    .run_led_q(run_led_q),
    .err_led_q(err_led_q),
    .ch_red_q(ch_red_q),
    .ch_orange_q(ch_orange_q),
    .safety_state_lamp_q(safety_state_lamp_q),
    .inoperative_diag_q(inoperative_diag_q)
);
